//--- include/fb_pkg.sv
package fb_pkg;
    // clock and the common hundredth-of-second tick
    localparam int unsigned CLK_PERIOD_NS = 4;
    localparam int unsigned TICK_TIME_NS = 10_000_000;
    localparam int unsigned TICK_CYCLES = TICK_TIME_NS / CLK_PERIOD_NS;
    localparam int unsigned TICK_DIV_W = 22;
    localparam int unsigned SEC_PER_MIN = 60;
    localparam int unsigned SEC_PER_HOUR = 3600;
    localparam int unsigned MIN_DIV_W = 6;
    localparam int unsigned HOUR_DIV_W = 12;

    // time settings in hundredths of the selected unit
    localparam int unsigned SET_W = 14;
    localparam logic [SET_W-1:0] SET_MIN = 14'h0001;
    localparam logic [SET_W-1:0] SET_MAX = 14'h270F;
    localparam logic [SET_W-1:0] SET_ONE = 14'h0001;
    localparam logic [SET_W-1:0] SET_ZERO = 14'h0000;

    // counters
    localparam int unsigned COUNT_W = 20;
    localparam logic [COUNT_W-1:0] PRESET_MIN = 20'h00001;
    localparam logic [COUNT_W-1:0] PRESET_MAX = 20'hF423F;
    localparam logic [COUNT_W-1:0] COUNT_ONE = 20'h00001;
    localparam logic [COUNT_W-1:0] COUNT_ZERO = 20'h00000;

    // analog levels in tenths of a volt
    localparam int unsigned LEVEL_W = 7;
    localparam logic [LEVEL_W-1:0] LEVEL_MAX = 7'h64;
    localparam int unsigned CHAN_N = 4;
    localparam int unsigned CHAN_W = 2;

    // positions of the binary inputs in the synchroniser vector
    localparam int unsigned IN_W = 10;
    localparam int unsigned IN_PT_EN = 0;
    localparam int unsigned IN_PT_RST = 1;
    localparam int unsigned IN_LD_TRIG = 2;
    localparam int unsigned IN_LD_RST = 3;
    localparam int unsigned IN_UC_COUNT = 4;
    localparam int unsigned IN_UC_RST = 5;
    localparam int unsigned IN_DC_COUNT = 6;
    localparam int unsigned IN_DC_RST = 7;
    localparam int unsigned IN_OS_TRIG = 8;
    localparam int unsigned IN_OS_RST = 9;

    typedef enum logic [2:0] {
        UNIT_HOUR = 3'h1,
        UNIT_MIN = 3'h2,
        UNIT_SEC = 3'h4
    } time_unit_t;

    typedef enum logic [1:0] {
        REL_GT = 2'h0,
        REL_LT = 2'h1,
        REL_GE = 2'h2,
        REL_LE = 2'h3
    } relation_t;

    typedef enum logic [2:0] {
        LD_IDLE = 3'h1,
        LD_TIMING = 3'h2,
        LD_HELD = 3'h4
    } latch_state_t;
endpackage

//--- include/time_base_if.sv
`timescale 1ns/1ns
`default_nettype none
interface time_base_if;
    logic tick_sec;
    logic tick_min;
    logic tick_hour;
    modport source (output tick_sec, output tick_min, output tick_hour);
    modport sink (input tick_sec, input tick_min, input tick_hour);
endinterface
`default_nettype wire

//--- design/duration_timer.sv
`timescale 1ns/1ns
`default_nettype none
module duration_timer (
    input wire logic clk,
    input wire logic rst_b,
    time_base_if.sink tb,
    input wire logic clear,
    input wire logic run,
    input wire fb_pkg::time_unit_t unit,
    input wire logic [fb_pkg::SET_W-1:0] period,
    output logic expire_q
);
    logic [fb_pkg::SET_W-1:0] elapsed_q;
    logic tick;

    always_comb begin
        case (unit)
            fb_pkg::UNIT_HOUR: tick = tb.tick_hour;
            fb_pkg::UNIT_MIN: tick = tb.tick_min;
            default: tick = tb.tick_sec;
        endcase
    end

    // (RL22) counts shared hundredth ticks
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            elapsed_q <= fb_pkg::SET_ZERO;
            expire_q <= 1'b0;
        end else begin
            expire_q <= 1'b0;
            if (clear) begin
                elapsed_q <= fb_pkg::SET_ZERO;
            end else if (run && tick) begin
                // a zero period behaves as one tick
                if (elapsed_q + fb_pkg::SET_ONE >= period) begin
                    elapsed_q <= fb_pkg::SET_ZERO;
                    expire_q <= 1'b1;
                end else begin
                    elapsed_q <= elapsed_q + fb_pkg::SET_ONE;
                end
            end
        end
    end
endmodule
`default_nettype wire

//--- design/timer_counter_function_blocks.sv
// Behaviour
// (RL1) pulse train period 0.01..99.99, h/m/s
// (RL2) enabled pulse train toggles each period
// (RL3) enable low stops timing, output low
// (RL4) reset forces low; restart from low
// (RL5) trigger rise starts delay, then output high
// (RL6) latched output ignores trigger; reset clears
// (RL7) delay reset overrides trigger, clears timer
// (RL8) delay setting 0.01..99.99, h/m/s
// (RL9) up counter reset wins, clears count
// (RL10) up counter adds one per rising edge; the code holds the count at 999999
// (RL11) up output high at preset count
// (RL12) preset is 1..999999
// (RL13) down counter reset wins, clears count
// (RL14) down counter subtracts one per edge; the code wraps a zero count to 999999
// (RL15) down output high at zero, not reset
// (RL16) trigger rise gives one pulse of duration
// (RL17) one-shot reset forces output low
// (RL18) pulse duration 0.01..99.99, h/m/s
// (RL19) operand is constant 0..10.0 or channel
// (RL20) compare by selected relation drives output
// (RL21) edges found against previous sample
// (RL22) shared hundredth tick; reset clears all
`timescale 1ns/1ns
`default_nettype none
module timer_counter_function_blocks #(
    parameter int unsigned TICK_CYCLES = fb_pkg::TICK_CYCLES
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic pulse_train_enable,
    input wire logic pulse_train_reset,
    input wire fb_pkg::time_unit_t pulse_train_unit,
    input wire logic [fb_pkg::SET_W-1:0] pulse_train_period,
    input wire logic latching_trigger_input,
    input wire logic latching_reset,
    input wire fb_pkg::time_unit_t latching_unit,
    input wire logic [fb_pkg::SET_W-1:0] latching_delay,
    input wire logic up_count_pulse_input,
    input wire logic up_reset,
    input wire logic [fb_pkg::COUNT_W-1:0] up_preset_value,
    input wire logic down_count_pulse_input,
    input wire logic down_reset,
    input wire logic one_shot_trigger_input,
    input wire logic one_shot_reset,
    input wire fb_pkg::time_unit_t one_shot_unit,
    input wire logic [fb_pkg::SET_W-1:0] one_shot_duration,
    input wire logic [fb_pkg::CHAN_N-1:0][fb_pkg::LEVEL_W-1:0] analog_level,
    input wire logic first_is_constant,
    input wire logic [fb_pkg::CHAN_W-1:0] first_channel,
    input wire logic [fb_pkg::LEVEL_W-1:0] first_constant,
    input wire logic second_is_constant,
    input wire logic [fb_pkg::CHAN_W-1:0] second_channel,
    input wire logic [fb_pkg::LEVEL_W-1:0] second_constant,
    input wire fb_pkg::relation_t compare_relation,
    output logic pulse_train_out_q,
    output logic latching_out_q,
    output logic up_out_q,
    output logic [fb_pkg::COUNT_W-1:0] up_value_q,
    output logic down_out_q,
    output logic [fb_pkg::COUNT_W-1:0] down_value_q,
    output logic one_shot_out_q,
    output logic compare_out_q
);
    time_base_if tb ();

    logic [fb_pkg::IN_W-1:0] in_raw;
    logic [fb_pkg::IN_W-1:0] meta_q;
    logic [fb_pkg::IN_W-1:0] sync_q;
    logic [fb_pkg::IN_W-1:0] prev_q;
    logic [fb_pkg::IN_W-1:0] rise;

    logic [fb_pkg::TICK_DIV_W-1:0] tick_div_q;
    logic [fb_pkg::MIN_DIV_W-1:0] min_div_q;
    logic [fb_pkg::HOUR_DIV_W-1:0] hour_div_q;
    logic base_tick;

    logic pt_run;
    logic pt_expire;
    logic [fb_pkg::SET_W-1:0] pt_period;

    fb_pkg::latch_state_t ld_state_q;
    logic ld_expire;
    logic [fb_pkg::SET_W-1:0] ld_period;

    logic [fb_pkg::COUNT_W-1:0] up_preset;

    logic os_expire;
    logic os_restart;
    logic [fb_pkg::SET_W-1:0] os_period;

    logic [fb_pkg::LEVEL_W-1:0] first_level;
    logic [fb_pkg::LEVEL_W-1:0] second_level;
    logic relation_holds;

    assign in_raw = {
        one_shot_reset,
        one_shot_trigger_input,
        down_reset,
        down_count_pulse_input,
        up_reset,
        up_count_pulse_input,
        latching_reset,
        latching_trigger_input,
        pulse_train_reset,
        pulse_train_enable
    };

    // terminals are asynchronous to clk
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= in_raw;
            sync_q <= meta_q;
        end
    end

    // (RL21) previous sample for edges
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            prev_q <= '0;
        end else begin
            prev_q <= sync_q;
        end
    end

    assign rise = sync_q & ~prev_q;

    // (RL22) hundredth-second base tick
    assign base_tick = (tick_div_q == fb_pkg::TICK_DIV_W'(TICK_CYCLES - 1));

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            tick_div_q <= '0;
            min_div_q <= '0;
            hour_div_q <= '0;
            tb.tick_sec <= 1'b0;
            tb.tick_min <= 1'b0;
            tb.tick_hour <= 1'b0;
        end else begin
            tb.tick_sec <= base_tick;
            tb.tick_min <= 1'b0;
            tb.tick_hour <= 1'b0;
            if (base_tick) begin
                tick_div_q <= '0;
                // minute and hour division
                if (min_div_q == fb_pkg::MIN_DIV_W'(fb_pkg::SEC_PER_MIN - 1)) begin
                    min_div_q <= '0;
                    tb.tick_min <= 1'b1;
                end else begin
                    min_div_q <= min_div_q + 1'b1;
                end
                if (hour_div_q == fb_pkg::HOUR_DIV_W'(fb_pkg::SEC_PER_HOUR - 1)) begin
                    hour_div_q <= '0;
                    tb.tick_hour <= 1'b1;
                end else begin
                    hour_div_q <= hour_div_q + 1'b1;
                end
            end else begin
                tick_div_q <= tick_div_q + 1'b1;
            end
        end
    end

    // (RL1) setting clamped into range
    assign pt_period = (pulse_train_period > fb_pkg::SET_MAX) ? fb_pkg::SET_MAX
        : (pulse_train_period < fb_pkg::SET_MIN) ? fb_pkg::SET_MIN : pulse_train_period;
    // (RL8) setting clamped into range
    assign ld_period = (latching_delay > fb_pkg::SET_MAX) ? fb_pkg::SET_MAX
        : (latching_delay < fb_pkg::SET_MIN) ? fb_pkg::SET_MIN : latching_delay;
    // (RL18) setting clamped into range
    assign os_period = (one_shot_duration > fb_pkg::SET_MAX) ? fb_pkg::SET_MAX
        : (one_shot_duration < fb_pkg::SET_MIN) ? fb_pkg::SET_MIN : one_shot_duration;

    // (RL3) runs only while enabled
    assign pt_run = sync_q[fb_pkg::IN_PT_EN] && !sync_q[fb_pkg::IN_PT_RST];

    // starts mid-tick: first interval may be one tick short
    duration_timer pt_timer (
        .clk(clk),
        .rst_b(rst_b),
        .tb(tb.sink),
        .clear(!pt_run),
        .run(pt_run),
        .unit(pulse_train_unit),
        .period(pt_period),
        .expire_q(pt_expire)
    );

    // (RL2) toggle at every expiry
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pulse_train_out_q <= 1'b0;
        end else if (!pt_run) begin
            // (RL4) reset or disable forces low
            pulse_train_out_q <= 1'b0;
        end else if (pt_expire) begin
            pulse_train_out_q <= !pulse_train_out_q;
        end
    end

    duration_timer ld_timer (
        .clk(clk),
        .rst_b(rst_b),
        .tb(tb.sink),
        .clear(ld_state_q != fb_pkg::LD_TIMING),
        .run(ld_state_q == fb_pkg::LD_TIMING),
        .unit(latching_unit),
        .period(ld_period),
        .expire_q(ld_expire)
    );

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ld_state_q <= fb_pkg::LD_IDLE;
        end else if (sync_q[fb_pkg::IN_LD_RST]) begin
            // (RL7) reset overrides trigger
            ld_state_q <= fb_pkg::LD_IDLE;
        end else begin
            case (ld_state_q)
                fb_pkg::LD_IDLE: begin
                    // (RL5) rising trigger starts delay
                    if (rise[fb_pkg::IN_LD_TRIG]) begin
                        ld_state_q <= fb_pkg::LD_TIMING;
                    end
                end
                fb_pkg::LD_TIMING: begin
                    if (ld_expire) begin
                        ld_state_q <= fb_pkg::LD_HELD;
                    end
                end
                // (RL6) held until reset
                fb_pkg::LD_HELD: ld_state_q <= fb_pkg::LD_HELD;
                default: ld_state_q <= fb_pkg::LD_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            latching_out_q <= 1'b0;
        end else if (sync_q[fb_pkg::IN_LD_RST]) begin
            latching_out_q <= 1'b0;
        end else if (ld_state_q == fb_pkg::LD_TIMING && ld_expire) begin
            latching_out_q <= 1'b1;
        end
    end

    // (RL12) preset held to 1..999999
    assign up_preset = (up_preset_value > fb_pkg::PRESET_MAX) ? fb_pkg::PRESET_MAX
        : (up_preset_value < fb_pkg::PRESET_MIN) ? fb_pkg::PRESET_MIN : up_preset_value;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            up_value_q <= fb_pkg::COUNT_ZERO;
        end else if (sync_q[fb_pkg::IN_UC_RST]) begin
            // (RL9) reset clears count
            up_value_q <= fb_pkg::COUNT_ZERO;
        end else if (rise[fb_pkg::IN_UC_COUNT] && up_value_q != fb_pkg::PRESET_MAX) begin
            // (RL10) one per rising edge, holds at 999999
            up_value_q <= up_value_q + fb_pkg::COUNT_ONE;
        end
    end

    // (RL11) high once preset reached
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            up_out_q <= 1'b0;
        end else if (sync_q[fb_pkg::IN_UC_RST]) begin
            up_out_q <= 1'b0;
        end else begin
            up_out_q <= (up_value_q >= up_preset);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            down_value_q <= fb_pkg::COUNT_ZERO;
        end else if (sync_q[fb_pkg::IN_DC_RST]) begin
            // (RL13) reset clears count
            down_value_q <= fb_pkg::COUNT_ZERO;
        end else if (rise[fb_pkg::IN_DC_COUNT]) begin
            // (RL14) one less per edge, zero wraps to the top
            if (down_value_q == fb_pkg::COUNT_ZERO) begin
                down_value_q <= fb_pkg::PRESET_MAX;
            end else begin
                down_value_q <= down_value_q - fb_pkg::COUNT_ONE;
            end
        end
    end

    // (RL15) high at zero outside reset
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            down_out_q <= 1'b0;
        end else if (sync_q[fb_pkg::IN_DC_RST]) begin
            down_out_q <= 1'b0;
        end else begin
            down_out_q <= (down_value_q == fb_pkg::COUNT_ZERO);
        end
    end

    // a new edge during a pulse restarts the full duration
    assign os_restart = rise[fb_pkg::IN_OS_TRIG] && !sync_q[fb_pkg::IN_OS_RST];

    duration_timer os_timer (
        .clk(clk),
        .rst_b(rst_b),
        .tb(tb.sink),
        .clear(os_restart || !one_shot_out_q),
        .run(one_shot_out_q),
        .unit(one_shot_unit),
        .period(os_period),
        .expire_q(os_expire)
    );

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            one_shot_out_q <= 1'b0;
        end else if (sync_q[fb_pkg::IN_OS_RST]) begin
            // (RL17) reset ends any pulse
            one_shot_out_q <= 1'b0;
        end else if (os_restart) begin
            // (RL16) pulse starts on rising edge
            one_shot_out_q <= 1'b1;
        end else if (os_expire) begin
            one_shot_out_q <= 1'b0;
        end
    end

    // (RL19) constant or channel operands
    always_comb begin
        first_level = first_is_constant ? first_constant : analog_level[first_channel];
        second_level = second_is_constant ? second_constant : analog_level[second_channel];
        if (first_is_constant && first_constant > fb_pkg::LEVEL_MAX) begin
            first_level = fb_pkg::LEVEL_MAX;
        end
        if (second_is_constant && second_constant > fb_pkg::LEVEL_MAX) begin
            second_level = fb_pkg::LEVEL_MAX;
        end
    end

    // (RL20) selected relation
    always_comb begin
        case (compare_relation)
            fb_pkg::REL_GT: relation_holds = first_level > second_level;
            fb_pkg::REL_LT: relation_holds = first_level < second_level;
            fb_pkg::REL_GE: relation_holds = first_level >= second_level;
            fb_pkg::REL_LE: relation_holds = first_level <= second_level;
            default: relation_holds = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            compare_out_q <= 1'b0;
        end else begin
            compare_out_q <= relation_holds;
        end
    end
endmodule
`default_nettype wire

//--- verif/count_source.sv
`timescale 1ns/1ns
`default_nettype none
module count_source (
    input wire logic clk,
    input wire logic go,
    input wire logic [7:0] n,
    output var logic line = 1'h0,
    output var logic busy = 1'h0
);
    logic [7:0] left = 8'h00;
    logic [2:0] ph = 3'h0;
    // 3 high, 3 low: outlasts the synchroniser
    always @(posedge clk) begin
        if (!busy) begin
            busy <= go && n != 8'h00;
            left <= n;
            ph <= 3'h0;
            line <= 1'h0;
        end else begin
            ph <= (ph == 3'h5) ? 3'h0 : ph + 3'h1;
            line <= ph < 3'h3;
            if (ph == 3'h5) begin
                left <= left - 8'h01;
                busy <= left != 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

//--- verif/tcfb_chk.sv
`timescale 1ns/1ns
`default_nettype none
module tcfb_chk (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic pulse_train_enable,
    input wire logic pulse_train_reset,
    input wire logic latching_reset,
    input wire logic up_reset,
    input wire logic down_reset,
    input wire logic one_shot_reset,
    input wire logic [fb_pkg::CHAN_N-1:0][fb_pkg::LEVEL_W-1:0] analog_level,
    input wire logic first_is_constant,
    input wire logic [fb_pkg::CHAN_W-1:0] first_channel,
    input wire logic [fb_pkg::LEVEL_W-1:0] first_constant,
    input wire logic second_is_constant,
    input wire logic [fb_pkg::CHAN_W-1:0] second_channel,
    input wire logic [fb_pkg::LEVEL_W-1:0] second_constant,
    input wire fb_pkg::relation_t compare_relation,
    input wire logic pulse_train_out_q,
    input wire logic latching_out_q,
    input wire logic up_out_q,
    input wire logic [fb_pkg::COUNT_W-1:0] up_value_q,
    input wire logic down_out_q,
    input wire logic [fb_pkg::COUNT_W-1:0] down_value_q,
    input wire logic one_shot_out_q,
    input wire logic compare_out_q
);
    logic [fb_pkg::LEVEL_W-1:0] op_a, op_b;
    logic hit;
    always_comb begin
        op_a = first_is_constant ? first_constant : analog_level[first_channel];
        op_b = second_is_constant ? second_constant : analog_level[second_channel];
        // only constants are clamped to full scale
        if (first_is_constant && op_a > fb_pkg::LEVEL_MAX) op_a = fb_pkg::LEVEL_MAX;
        if (second_is_constant && op_b > fb_pkg::LEVEL_MAX) op_b = fb_pkg::LEVEL_MAX;
        case (compare_relation)
            fb_pkg::REL_GT: hit = op_a > op_b;
            fb_pkg::REL_LT: hit = op_a < op_b;
            fb_pkg::REL_GE: hit = op_a >= op_b;
            default: hit = op_a <= op_b;
        endcase
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // four samples cover the synchroniser
    sequence s_hi(x); x [*4]; endsequence
    sequence s_lo(x); !x [*4]; endsequence
    property p_pt_stop; s_lo(pulse_train_enable) |=> !pulse_train_out_q; endproperty
    a_pt_stop: assert property (p_pt_stop) else $error("train on");
    property p_pt_rst; s_hi(pulse_train_reset) |=> !pulse_train_out_q; endproperty
    a_pt_rst: assert property (p_pt_rst) else $error("train rst");
    property p_ld_rst; s_hi(latching_reset) |=> !latching_out_q; endproperty
    a_ld_rst: assert property (p_ld_rst) else $error("delay rst");
    property p_ld_hold; s_lo(latching_reset) ##0 latching_out_q |=> latching_out_q; endproperty
    a_ld_hold: assert property (p_ld_hold) else $error("delay drop");
    property p_uc_rst; s_hi(up_reset) |=> up_value_q == '0 && !up_out_q; endproperty
    a_uc_rst: assert property (p_uc_rst) else $error("up rst");
    property p_uc_step;
        $changed(up_value_q) |->
            up_value_q == $past(up_value_q) + fb_pkg::COUNT_ONE || up_value_q == '0;
    endproperty
    a_uc_step: assert property (p_uc_step) else $error("up step");
    property p_dc_step;
        $changed(down_value_q) |-> down_value_q == '0 ||
            down_value_q == fb_pkg::PRESET_MAX ||
            down_value_q == $past(down_value_q) - fb_pkg::COUNT_ONE;
    endproperty
    a_dc_step: assert property (p_dc_step) else $error("down step");
    property p_dc_zero; s_lo(down_reset) |=> down_out_q == ($past(down_value_q) == '0); endproperty
    a_dc_zero: assert property (p_dc_zero) else $error("down zero");
    property p_os_rst; s_hi(one_shot_reset) |=> !one_shot_out_q; endproperty
    a_os_rst: assert property (p_os_rst) else $error("shot rst");
    property p_cmp; $past(rst_b) |=> compare_out_q == $past(hit); endproperty
    a_cmp: assert property (p_cmp) else $error("compare");
endmodule
bind timer_counter_function_blocks tcfb_chk u_chk (.*);
`default_nettype wire

//--- verif/timer_counter_function_blocks_tb.sv
`timescale 1ns/1ns
`default_nettype none
module timer_counter_function_blocks_tb;
    localparam int TC = 4;
    bit clk, rst_b, pulse_train_enable, pulse_train_reset, latching_trigger_input;
    bit latching_reset, up_reset, down_reset, one_shot_trigger_input, one_shot_reset;
    logic first_is_constant = 1'h1, second_is_constant = 1'h0;
    fb_pkg::time_unit_t pulse_train_unit = fb_pkg::UNIT_SEC, latching_unit = fb_pkg::UNIT_SEC;
    fb_pkg::time_unit_t one_shot_unit = fb_pkg::UNIT_SEC;
    logic [13:0] pulse_train_period = 14'h0003, latching_delay = 14'h0003;
    logic [13:0] one_shot_duration = 14'h0002;
    logic [19:0] up_preset_value = 20'h00005, up_value_q, down_value_q;
    logic [3:0][6:0] analog_level = '0;
    logic [1:0] first_channel = 2'h0, second_channel = 2'h1;
    logic [6:0] first_constant = 7'h32, second_constant = 7'h00;
    fb_pkg::relation_t compare_relation = fb_pkg::REL_GT;
    logic pulse_train_out_q, latching_out_q, up_out_q, down_out_q, one_shot_out_q, compare_out_q;
    logic up_count_pulse_input, down_count_pulse_input, up_busy, dn_busy;
    bit up_go, dn_go;
    bit [7:0] cnt_n;
    int failures = 0, total_checks = 0;
    always #2 clk = ~clk;
    timer_counter_function_blocks #(.TICK_CYCLES(TC)) dut (.*);
    count_source up_src (.clk(clk), .go(up_go), .n(cnt_n), .line(up_count_pulse_input),
        .busy(up_busy));
    count_source dn_src (.clk(clk), .go(dn_go), .n(cnt_n), .line(down_count_pulse_input),
        .busy(dn_busy));
    task print_verdict;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task chk(input bit ok, input string m);
        total_checks++;
        if (!ok) begin
            failures++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task pt_gap(output int n);
        logic v;
        v = pulse_train_out_q;
        n = 0;
        while (pulse_train_out_q === v) begin
            cyc(1);
            n++;
        end
    endtask
    task send(input bit dn, input logic [7:0] n);
        @(posedge clk) {cnt_n, up_go, dn_go} <= {n, !dn, dn};
        @(posedge clk) {up_go, dn_go} <= 2'h0;
        cyc(1);
        while (up_busy || dn_busy) cyc(1);
        cyc(6);
    endtask
    task t_pulse(input fb_pkg::time_unit_t u, input logic [13:0] p, input int e);
        int g;
        @(posedge clk) begin
            pulse_train_unit <= u;
            pulse_train_period <= p;
            pulse_train_enable <= 1'h1;
        end
        pt_gap(g);
        pt_gap(g);
        chk(pulse_train_out_q === 1'h0 && g == e, "pulse period");
        @(posedge clk) pulse_train_enable <= 1'h0;
        cyc(5);
        chk(pulse_train_out_q === 1'h0, "pulse stop");
    endtask
    task t_ptrst;
        int g;
        @(posedge clk) begin
            pulse_train_unit <= fb_pkg::UNIT_SEC;
            pulse_train_period <= 14'h0003;
            pulse_train_enable <= 1'h1;
        end
        pt_gap(g);
        @(posedge clk) pulse_train_reset <= 1'h1;
        cyc(5);
        chk(pulse_train_out_q === 1'h0, "pulse reset");
        @(posedge clk) pulse_train_reset <= 1'h0;
        cyc(4);
        chk(pulse_train_out_q === 1'h0, "restart low");
        pt_gap(g);
        chk(pulse_train_out_q === 1'h1 && g >= 6 && g <= 14, "restart rise");
        @(posedge clk) pulse_train_enable <= 1'h0;
    endtask
    task t_latch;
        @(posedge clk) latching_trigger_input <= 1'h1;
        cyc(8);
        chk(latching_out_q === 1'h0, "delay early");
        cyc(10);
        chk(latching_out_q === 1'h1, "delay done");
        @(posedge clk) latching_trigger_input <= 1'h0;
        cyc(20);
        chk(latching_out_q === 1'h1, "delay held");
        @(posedge clk) {latching_reset, latching_trigger_input} <= 2'h3;
        cyc(25);
        chk(latching_out_q === 1'h0, "delay reset");
        @(posedge clk) {latching_reset, latching_trigger_input} <= 2'h0;
    endtask
    task t_up;
        send(1'b0, 8'h04);
        chk(up_value_q === 20'h00004 && up_out_q === 1'h0, "up four");
        send(1'b0, 8'h01);
        chk(up_value_q === 20'h00005 && up_out_q === 1'h1, "up preset");
        @(posedge clk) {up_reset, up_preset_value} <= {1'h1, 20'h00000};
        send(1'b0, 8'h02);
        chk(up_value_q === 20'h00000 && up_out_q === 1'h0, "up reset");
        @(posedge clk) up_reset <= 1'h0;
        send(1'b0, 8'h01);
        chk(up_out_q === 1'h1, "preset floor");
    endtask
    task t_down;
        @(posedge clk) down_reset <= 1'h1;
        cyc(5);
        chk(down_value_q === 20'h00000 && down_out_q === 1'h0, "down reset");
        @(posedge clk) down_reset <= 1'h0;
        cyc(5);
        chk(down_out_q === 1'h1, "down zero");
        send(1'b1, 8'h03);
        chk(down_value_q === fb_pkg::PRESET_MAX - 20'h00002 && down_out_q === 1'h0, "down steps");
    endtask
    task t_shot;
        int n;
        @(posedge clk) one_shot_trigger_input <= 1'h1;
        while (one_shot_out_q !== 1'h1) cyc(1);
        n = 0;
        while (one_shot_out_q === 1'h1) begin
            cyc(1);
            n++;
        end
        chk(n >= 5 && n <= 10, "pulse width");
        @(posedge clk) one_shot_trigger_input <= 1'h0;
        cyc(4);
        @(posedge clk) one_shot_trigger_input <= 1'h1;
        cyc(5);
        @(posedge clk) one_shot_reset <= 1'h1;
        cyc(5);
        chk(one_shot_out_q === 1'h0, "one-shot reset");
        @(posedge clk) one_shot_reset <= 1'h0;
    endtask
    task t_cmp;
        logic e;
        logic [6:0] b;
        for (int r = 0; r < 4; r++) begin
            for (int k = 0; k < 3; k++) begin
                b = 7'h28 + 7'(k * 10);
                @(posedge clk) begin
                    compare_relation <= fb_pkg::relation_t'(r);
                    analog_level[1] <= b;
                end
                cyc(2);
                e = r == 0 ? 7'h32 > b : r == 1 ? 7'h32 < b : r == 2 ? 7'h32 >= b : 7'h32 <= b;
                chk(compare_out_q === e, "relation");
            end
        end
        @(posedge clk) begin
            {first_is_constant, first_channel, second_is_constant} <= 4'h5;
            {analog_level[2], second_constant} <= {7'h64, 7'h7F};
            compare_relation <= fb_pkg::REL_GE;
        end
        cyc(2);
        chk(compare_out_q === 1'h1, "clamped constant");
    endtask
    initial begin
        #400000;
        failures++;
        print_verdict;
    end
    initial begin
        cyc(5);
        chk({pulse_train_out_q, latching_out_q, up_out_q, down_out_q, one_shot_out_q,
            compare_out_q} === 6'h00 && up_value_q === 20'h00000, "in reset");
        @(posedge clk) rst_b <= 1'h1;
        t_pulse(fb_pkg::UNIT_SEC, 14'h0000, TC);
        t_pulse(fb_pkg::UNIT_SEC, 14'h0003, 3 * TC);
        t_pulse(fb_pkg::time_unit_t'(3'h0), 14'h0002, 2 * TC);
        t_pulse(fb_pkg::UNIT_MIN, 14'h0001, fb_pkg::SEC_PER_MIN * TC);
        t_pulse(fb_pkg::UNIT_HOUR, 14'h0001, fb_pkg::SEC_PER_HOUR * TC);
        t_ptrst;
        t_latch;
        t_up;
        t_down;
        t_shot;
        t_cmp;
        @(posedge clk) rst_b <= 1'h0;
        cyc(2);
        chk(up_value_q === 20'h00000 && down_value_q === 20'h00000, "second reset");
        print_verdict;
    end
endmodule
`default_nettype wire
